// file: rtl/scope_trigger_integration_cfg.sv
// Purpose: apply scope trigger settings and run timed integration
// Assumes: inputs synchronous to ref_clk_i; level and samples share one scale
// Notes:   integration times counted in whole seconds of clock cycles
`timescale 1ns/1ps
module scope_trigger_integration_cfg #(
   parameter int SAMPLE_W   = 16,
   parameter int SEC_CYCLES = scope_integ_pkg::SEC_CYCLES
) (
   input  wire logic                                  ref_clk_i,
   input  wire logic                                  sys_rst_i,
   input  wire logic                                  capture_surge_override_i,
   input  wire logic                                  capture_active_i,
   input  wire logic                                  range_high_i,
   input  wire logic                                  bw_unfiltered_i,
   input  wire logic [scope_integ_pkg::TB_W-1:0]      timebase_code_i,
   input  wire logic [2:0]                            trig_source_i,
   input  wire logic [1:0]                            trig_method_i,
   input  wire logic [1:0]                            trig_position_i,
   input  wire logic signed [SAMPLE_W-1:0]            trig_level_i,
   input  wire logic signed [SAMPLE_W-1:0]            volt_sample_i [4],
   input  wire logic signed [SAMPLE_W-1:0]            curr_sample_i [4],
   input  wire logic                                  hf_detect_i,
   input  wire logic                                  accumulate_auto_timing_i,
   input  wire logic [6:0]                            accumulate_start_wait_i [4],
   input  wire logic [6:0]                            accumulate_run_span_i [4],
   input  wire logic                                  auto_start_i,
   input  wire logic                                  manual_start_i,
   input  wire logic                                  manual_stop_i,
   output logic                                       range_high_o,
   output logic                                       bw_unfiltered_o,
   output logic [scope_integ_pkg::TB_NS_W-1:0]        capture_span_ns_o,
   output logic [1:0]                                 trig_channel_o,
   output logic                                       trig_is_current_o,
   output logic [scope_integ_pkg::PCT_W-1:0]          trig_position_pct_o,
   output logic                                       trig_fire_o,
   output logic                                       integrating_o,
   output logic                                       integ_done_o
);
   // Elaboration-time guard; sign handling needs two sample bits at least
   if (SAMPLE_W < 2 || SEC_CYCLES < 1) begin : g_bad_param
      $error("scope_trigger_integration_cfg: bad parameter");
   end

   // ************************************************************
   // Capture settings
   // ************************************************************
   logic [scope_integ_pkg::TB_NS_W-1:0] span_ns;
   timebase_decode timebase_decode_i (
      .code_i    (timebase_code_i),
      .span_ns_o (span_ns)
   );

   logic                               range_reg, range_next;
   logic                               bw_reg, bw_next;
   logic [scope_integ_pkg::TB_NS_W-1:0] span_reg, span_next;
   logic [1:0]                         chan_reg, chan_next;
   logic                               cur_reg, cur_next;
   logic [scope_integ_pkg::PCT_W-1:0]   pct_reg, pct_next;

   always_comb begin
      // Override only while capturing, so normal settings return afterwards
      if (capture_surge_override_i && capture_active_i) begin
         range_next = 1'b1;
         bw_next    = 1'b1;
      end else begin
         range_next = range_high_i;
         bw_next    = bw_unfiltered_i;
      end
      span_next = span_ns;
      chan_next = trig_source_i[2:1];
      cur_next  = trig_source_i[0];
      unique case (trig_position_i)
         2'h0: pct_next = scope_integ_pkg::PCT_0;
         2'h1: pct_next = scope_integ_pkg::PCT_25;
         2'h2: pct_next = scope_integ_pkg::PCT_50;
         2'h3: pct_next = scope_integ_pkg::PCT_75;
      endcase
   end

   // ************************************************************
   // Trigger detection
   // ************************************************************
   logic signed [SAMPLE_W-1:0] sel_sample, mag_sample;
   logic                       above_reg, above_next;
   logic                       fire_reg, fire_next;
   scope_integ_pkg::trig_method_t method;

   always_comb begin
      method     = scope_integ_pkg::trig_method_t'(trig_method_i);
      // Level units follow the source kind; no scaling is done here
      sel_sample = trig_source_i[0] ? curr_sample_i[trig_source_i[2:1]]
                                    : volt_sample_i[trig_source_i[2:1]];
      mag_sample = (sel_sample < 0) ? -sel_sample : sel_sample;
      above_next = ((method == scope_integ_pkg::TRIG_RECT_RISE) ? mag_sample : sel_sample)
                   > trig_level_i;
      unique case (method)
         scope_integ_pkg::TRIG_DC_RISE:   fire_next = above_next && !above_reg;
         scope_integ_pkg::TRIG_DC_FALL:   fire_next = !above_next && above_reg;
         scope_integ_pkg::TRIG_RECT_RISE: fire_next = above_next && !above_reg;
         scope_integ_pkg::TRIG_HIGH_FREQ: fire_next = hf_detect_i;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         range_reg <= 1'b0;
         bw_reg    <= 1'b0;
         span_reg  <= '0;
         chan_reg  <= 2'h0;
         cur_reg   <= 1'b0;
         pct_reg   <= '0;
         above_reg <= 1'b0;
         fire_reg  <= 1'b0;
      end else begin
         range_reg <= range_next;
         bw_reg    <= bw_next;
         span_reg  <= span_next;
         chan_reg  <= chan_next;
         cur_reg   <= cur_next;
         pct_reg   <= pct_next;
         above_reg <= above_next;
         fire_reg  <= fire_next;
      end
   end

   // ************************************************************
   // Integration timing
   // ************************************************************
   localparam int SW = scope_integ_pkg::SECS_W;
   logic [SW-1:0] wait_secs, run_secs;
   logic [6:0]    wf [4];
   logic [6:0]    rf [4];

   // Fields above 99 clamp; keeps the totals inside the counter width
   for (genvar g = 0; g < 4; g++) begin : g_clamp
      assign wf[g] = (accumulate_start_wait_i[g] > 7'(scope_integ_pkg::FIELD_MAX)) ?
                     7'(scope_integ_pkg::FIELD_MAX) : accumulate_start_wait_i[g];
      assign rf[g] = (accumulate_run_span_i[g] > 7'(scope_integ_pkg::FIELD_MAX)) ?
                     7'(scope_integ_pkg::FIELD_MAX) : accumulate_run_span_i[g];
   end

   always_comb begin
      wait_secs = SW'(wf[0] * scope_integ_pkg::SEC_PER_DAY + wf[1] * scope_integ_pkg::SEC_PER_HOUR
                  + wf[2] * scope_integ_pkg::SEC_PER_MIN + wf[3]);
      run_secs  = SW'(rf[0] * scope_integ_pkg::SEC_PER_DAY + rf[1] * scope_integ_pkg::SEC_PER_HOUR
                  + rf[2] * scope_integ_pkg::SEC_PER_MIN + rf[3]);
   end

   scope_integ_pkg::integ_state_t state_reg, state_next;
   logic [31:0]   tick_reg, tick_next;
   logic [SW-1:0] secs_reg, secs_next;
   logic          sec_tick;

   always_comb begin
      state_next = state_reg;
      tick_next  = tick_reg;
      secs_next  = secs_reg;
      sec_tick   = (tick_reg == 32'(SEC_CYCLES - 1));
      if (state_reg == scope_integ_pkg::INTEG_WAIT || state_reg == scope_integ_pkg::INTEG_RUN) begin
         tick_next = sec_tick ? 32'h00000000 : tick_reg + 32'h00000001;
         if (sec_tick) begin
            secs_next = secs_reg + SW'(1);
         end
      end
      unique case (state_reg)
         scope_integ_pkg::INTEG_IDLE, scope_integ_pkg::INTEG_DONE: begin
            if (accumulate_auto_timing_i && auto_start_i) begin
               state_next = (wait_secs == '0) ? scope_integ_pkg::INTEG_RUN
                                               : scope_integ_pkg::INTEG_WAIT;
               tick_next  = 32'h00000000;
               secs_next  = '0;
            end else if (!accumulate_auto_timing_i && manual_start_i) begin
               state_next = scope_integ_pkg::INTEG_RUN;
               tick_next  = 32'h00000000;
               secs_next  = '0;
            end
         end
         scope_integ_pkg::INTEG_WAIT: begin
            if (sec_tick && secs_reg + SW'(1) >= wait_secs) begin
               state_next = scope_integ_pkg::INTEG_RUN;
               secs_next  = '0;
            end
         end
         scope_integ_pkg::INTEG_RUN: begin
            if (!accumulate_auto_timing_i) begin
               if (manual_stop_i) begin
                  state_next = scope_integ_pkg::INTEG_DONE;
               end
            end else if (run_secs == '0 || (sec_tick && secs_reg + SW'(1) >= run_secs)) begin
               state_next = scope_integ_pkg::INTEG_DONE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= scope_integ_pkg::INTEG_IDLE;
         tick_reg  <= 32'h00000000;
         secs_reg  <= '0;
      end else begin
         state_reg <= state_next;
         tick_reg  <= tick_next;
         secs_reg  <= secs_next;
      end
   end

   assign range_high_o        = range_reg;
   assign bw_unfiltered_o     = bw_reg;
   assign capture_span_ns_o   = span_reg;
   assign trig_channel_o      = chan_reg;
   assign trig_is_current_o   = cur_reg;
   assign trig_position_pct_o = pct_reg;
   assign trig_fire_o         = fire_reg;
   assign integrating_o       = (state_reg == scope_integ_pkg::INTEG_RUN);
   assign integ_done_o        = (state_reg == scope_integ_pkg::INTEG_DONE);
endmodule // scope_trigger_integration_cfg

// file: shared/scope_integ_pkg.sv
// Purpose: constants for the scope trigger and integration timing block
// Assumes: one clock, plain configuration ports, no bus
// Notes:   times held in whole seconds, tick derived from the clock rate
package scope_integ_pkg;
   localparam int  CLK_HZ          = 200_000_000;
   localparam int  SEC_CYCLES      = CLK_HZ;
   localparam int  FIELD_MAX       = 99;
   localparam int  SEC_PER_MIN     = 60;
   localparam int  SEC_PER_HOUR    = 3600;
   localparam int  SEC_PER_DAY     = 86400;
   localparam int  TB_CODE_MAX     = 20;
   localparam int  TB_W            = 5;
   localparam int  TB_NS_W         = 36;
   localparam int  PCT_W           = 7;
   localparam int  SECS_W          = 24;
   localparam logic [6:0] PCT_0    = 7'h00;
   localparam logic [6:0] PCT_25   = 7'h19;
   localparam logic [6:0] PCT_50   = 7'h32;
   localparam logic [6:0] PCT_75   = 7'h4B;
   typedef enum logic [1:0] {
      TRIG_DC_RISE,
      TRIG_DC_FALL,
      TRIG_RECT_RISE,
      TRIG_HIGH_FREQ
   } trig_method_t;
   typedef enum logic [1:0] {
      INTEG_IDLE,
      INTEG_WAIT,
      INTEG_RUN,
      INTEG_DONE
   } integ_state_t;
endpackage

// file: rtl/timebase_decode.sv
// Purpose: timebase code to capture span in nanoseconds
// Assumes: codes above the top clamp to the longest span
// Notes:   pure combinational table
`timescale 1ns/1ps
module timebase_decode (
   input  wire logic [scope_integ_pkg::TB_W-1:0]    code_i,
   output logic      [scope_integ_pkg::TB_NS_W-1:0] span_ns_o
);
   logic [scope_integ_pkg::TB_NS_W-1:0] decade;
   logic [4:0]                           step;
   always_comb begin
      step   = (code_i > 5'(scope_integ_pkg::TB_CODE_MAX)) ?
               5'(scope_integ_pkg::TB_CODE_MAX) : code_i;
      decade = 36'h000000005;
      for (int k = 0; k < 7; k++) begin
         if (int'(step) >= 3 * k + 3) begin
            decade = decade * 36'h00000000A;
         end
      end
      // 1-2-5: position in decade selects x1, x2 or x4 of the base (5->10->20)
      unique case (step % 5'h03)
         5'h00:   span_ns_o = decade * 36'h0000003E8;
         5'h01:   span_ns_o = decade * 36'h0000007D0;
         default: span_ns_o = decade * 36'h000000FA0;
      endcase
   end
endmodule // timebase_decode

// file: tb/scope_integ_assertions.sv
// Purpose: port-level checks for scope trigger and integration settings
// Assumes: inputs change away from the sampling edge
// Notes:   timed integration lengths are judged by the bench, not here
`timescale 1ns/1ps
module scope_integ_assertions #(
   parameter int SEC_CYCLES = 4
) (
   input wire logic                                 ref_clk_i,
   input wire logic                                 sys_rst_i,
   input wire logic                                 capture_surge_override_i,
   input wire logic                                 capture_active_i,
   input wire logic [scope_integ_pkg::TB_W-1:0]     timebase_code_i,
   input wire logic [2:0]                           trig_source_i,
   input wire logic [1:0]                           trig_method_i,
   input wire logic [1:0]                           trig_position_i,
   input wire logic                                 hf_detect_i,
   input wire logic                                 accumulate_auto_timing_i,
   input wire logic                                 auto_start_i,
   input wire logic                                 manual_start_i,
   input wire logic                                 manual_stop_i,
   input wire logic                                 range_high_o,
   input wire logic                                 bw_unfiltered_o,
   input wire logic [scope_integ_pkg::TB_NS_W-1:0]  capture_span_ns_o,
   input wire logic [1:0]                           trig_channel_o,
   input wire logic                                 trig_is_current_o,
   input wire logic [scope_integ_pkg::PCT_W-1:0]    trig_position_pct_o,
   input wire logic                                 trig_fire_o,
   input wire logic                                 integrating_o,
   input wire logic                                 integ_done_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   a_surge_forces: assert property (capture_surge_override_i && capture_active_i
      |=> range_high_o && bw_unfiltered_o) else $error("surge override not applied");
   a_span_shortest: assert property (timebase_code_i == 5'h00
      |=> capture_span_ns_o == 36'h000001388) else $error("shortest span wrong");
   a_source_chan: assert property (1'b1 |=> trig_channel_o == $past(trig_source_i[2:1])
      && trig_is_current_o == $past(trig_source_i[0])) else $error("source decode wrong");
   a_half_pos: assert property (trig_position_i == 2'h2
      |=> trig_position_pct_o == scope_integ_pkg::PCT_50) else $error("half position wrong");
   a_quarter_pos: assert property (trig_position_i == 2'h1
      |=> trig_position_pct_o == scope_integ_pkg::PCT_25) else $error("quarter position wrong");
   a_hf_follow: assert property (trig_method_i == 2'h3
      |=> trig_fire_o == $past(hf_detect_i)) else $error("hf trigger not followed");
   a_fire_single: assert property (trig_fire_o && trig_method_i != 2'h3
      && $stable(trig_method_i) |=> !trig_fire_o) else $error("trigger fired twice");
   a_manual_stop: assert property (!accumulate_auto_timing_i && manual_stop_i
      && integrating_o |-> ##[1:2] !integrating_o) else $error("manual stop ignored");
   a_done_holds: assert property (integ_done_o && !auto_start_i && !manual_start_i
      |=> integ_done_o && !integrating_o) else $error("done not held until next start");
   cover property (trig_fire_o);
   cover property ($rose(integrating_o) && accumulate_auto_timing_i);
   cover property (range_high_o && capture_surge_override_i);
endmodule // scope_integ_assertions

// file: tb/integ_cmd_host.sv
// Purpose: controller stand-in turning commands into start and stop strobes
// Assumes: cmd_i changes just after an edge and holds for one cycle
// Notes:   strobes decoded straight from the command, no added delay
`timescale 1ns/1ps
module integ_cmd_host (
   input  wire logic [1:0] cmd_i,
   output logic            auto_start_o,
   output logic            manual_start_o,
   output logic            manual_stop_o
);
   // Code 1 timed start, 2 manual start, 3 manual stop
   assign auto_start_o   = (cmd_i == 2'h1);
   assign manual_start_o = (cmd_i == 2'h2);
   assign manual_stop_o  = (cmd_i == 2'h3);
endmodule // integ_cmd_host

// file: tb/scope_trigger_integration_cfg_test.sv
// Purpose: self-checking bench for scope trigger and integration settings
// Assumes: SEC_CYCLES shortened to 4, so one second is four clocks
// Notes:   days field untimed, one day would blow the run length
`timescale 1ns/1ps
module scope_trigger_integration_cfg_test;
   localparam int SC = 4;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i, capture_surge_override_i, capture_active_i, range_high_i, bw_unfiltered_i;
   logic hf_detect_i, accumulate_auto_timing_i, auto_start_i, manual_start_i, manual_stop_i;
   logic range_high_o, bw_unfiltered_o, trig_is_current_o, trig_fire_o, integrating_o;
   logic integ_done_o;
   logic [4:0] timebase_code_i;
   logic [2:0] trig_source_i;
   logic [1:0] trig_method_i, trig_position_i, trig_channel_o, cmd;
   logic [6:0] trig_position_pct_o;
   logic [35:0] capture_span_ns_o;
   logic signed [15:0] trig_level_i;
   logic signed [15:0] volt_sample_i [4];
   logic signed [15:0] curr_sample_i [4];
   logic [6:0] accumulate_start_wait_i [4];
   logic [6:0] accumulate_run_span_i [4];
   int n_mismatch = 0;
   int n_compared = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   scope_trigger_integration_cfg #(.SEC_CYCLES(SC)) scope_trigger_integration_cfg_i (.*);
   integ_cmd_host integ_cmd_host_i (.cmd_i(cmd), .auto_start_o(auto_start_i),
      .manual_start_o(manual_start_i), .manual_stop_o(manual_stop_i));
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_surge;
      for (int k = 0; k < 16; k++) begin
         {capture_surge_override_i, capture_active_i, range_high_i, bw_unfiltered_i} = k[3:0];
         tick(1);
         chk("range", 36'(k[3] & k[2] | k[1]), 36'(range_high_o));
         chk("bandwidth", 36'(k[3] & k[2] | k[0]), 36'(bw_unfiltered_o));
      end
   endtask
   task automatic t_decode;
      longint span;
      for (int k = 0; k < 21; k++) begin
         span = (k % 3 == 0) ? 5000 : (k % 3 == 1) ? 10000 : 20000;
         repeat (k / 3) span = span * 10;
         timebase_code_i = k[4:0];
         trig_source_i = k[2:0];
         trig_position_i = k[1:0];
         tick(1);
         chk("span", span[35:0], capture_span_ns_o);
         chk("channel", 36'(k[2:1]), 36'(trig_channel_o));
         chk("current", 36'(k[0]), 36'(trig_is_current_o));
         chk("position", 36'(25 * k[1:0]), 36'(trig_position_pct_o));
      end
      // Codes above the top clamp to the longest span
      timebase_code_i = 5'h1F;
      tick(1);
      chk("span clamp", 36'h4A817C800, capture_span_ns_o);
   endtask
   task automatic drive_sample(input logic [2:0] src, input logic signed [15:0] s);
      if (src[0]) begin
         curr_sample_i[src[2:1]] = s;
      end else begin
         volt_sample_i[src[2:1]] = s;
      end
   endtask
   // Long settle first, so a crossing from the previous call never leaks in
   task automatic t_fire(input logic [2:0] src, input logic [1:0] m,
                         input logic signed [15:0] s0, s1, input int exp);
      int hits;
      hits = 0;
      trig_source_i = src;
      trig_method_i = m;
      drive_sample(src, s0);
      tick(4);
      drive_sample(src, s1);
      hf_detect_i = (m == 2'h3);
      tick(1);
      hf_detect_i = 1'b0;
      repeat (4) begin
         hits += int'(trig_fire_o === 1'b1);
         tick(1);
      end
      chk("fire count", 36'(exp), 36'(hits));
   endtask
   task automatic t_manual;
      accumulate_auto_timing_i = 1'b0;
      cmd = 2'h1;
      tick(1);
      cmd = 2'h0;
      tick(3);
      chk("timed start in manual", 36'h0, 36'(integrating_o));
      cmd = 2'h2;
      tick(1);
      cmd = 2'h0;
      tick(6);
      chk("manual running", 36'h1, 36'(integrating_o));
      cmd = 2'h3;
      tick(1);
      cmd = 2'h0;
      tick(1);
      chk("manual stopped", 36'h0, 36'(integrating_o));
   endtask
   // Reset in mid-run must drop a running integration and clear the settings
   task automatic t_reset;
      accumulate_auto_timing_i = 1'b0;
      timebase_code_i = 5'h14;
      trig_position_i = 2'h3;
      cmd = 2'h2;
      tick(1);
      cmd = 2'h0;
      sys_rst_i = 1'b1;
      tick(2);
      chk("integrating in reset", 36'h0, 36'(integrating_o));
      chk("span in reset", 36'h0, capture_span_ns_o);
      chk("position in reset", 36'h0, 36'(trig_position_pct_o));
      sys_rst_i = 1'b0;
      tick(1);
      chk("span after reset", 36'h4A817C800, capture_span_ns_o);
      chk("position after reset", 36'h4B, 36'(trig_position_pct_o));
   endtask
   task automatic t_auto(input logic [27:0] w, input logic [27:0] r);
      int k;
      int exp_cyc;
      for (int f = 0; f < 4; f++) begin
         accumulate_start_wait_i[f] = w[27-7*f -: 7];
         accumulate_run_span_i[f] = r[27-7*f -: 7];
      end
      accumulate_auto_timing_i = 1'b1;
      cmd = 2'h1;
      tick(1);
      cmd = 2'h0;
      k = 0;
      while (integrating_o !== 1'b1 && k < 20000) begin
         tick(1);
         k++;
      end
      // Wait is whole seconds of SC clocks, counted from the start edge
      exp_cyc = (86400 * w[27:21] + 3600 * w[20:14] + 60 * w[13:7] + w[6:0]) * SC;
      chk("wait cycles", 36'(exp_cyc), 36'(k));
      if (k == 20000) report_and_stop;
      k = 0;
      while (integrating_o === 1'b1 && k < 20000) begin
         tick(1);
         k++;
      end
      exp_cyc = (86400 * r[27:21] + 3600 * r[20:14] + 60 * r[13:7] + r[6:0]) * SC;
      chk("run cycles", 36'(exp_cyc), 36'(k));
      if (k == 20000) report_and_stop;
      chk("done", 36'h1, 36'(integ_done_o));
   endtask
   initial begin
      {capture_surge_override_i, capture_active_i, range_high_i, bw_unfiltered_i} = 4'h0;
      {hf_detect_i, accumulate_auto_timing_i, cmd, timebase_code_i} = 9'h000;
      {trig_source_i, trig_method_i, trig_position_i} = 7'h00;
      trig_level_i = 16'sh0064;
      foreach (volt_sample_i[f]) begin
         volt_sample_i[f] = 16'sh0000;
         curr_sample_i[f] = 16'sh0000;
         accumulate_start_wait_i[f] = 7'h00;
         accumulate_run_span_i[f] = 7'h00;
      end
      sys_rst_i = 1'b1;
      tick(10);
      sys_rst_i = 1'b0;
      t_surge;
      t_decode;
      t_fire(3'h0, 2'h0, 16'sh0000, 16'sh00C8, 1);
      t_fire(3'h0, 2'h0, 16'sh00C8, 16'sh0064, 0);
      t_fire(3'h0, 2'h1, 16'sh00C8, 16'sh0064, 1);
      t_fire(3'h0, 2'h2, 16'sh0000, -16'sh00C8, 1);
      t_fire(3'h0, 2'h3, 16'sh0000, 16'sh0000, 1);
      t_fire(3'h7, 2'h0, 16'sh0000, 16'sh00C8, 1);
      t_manual;
      t_reset;
      t_auto(28'h0000001, 28'h0000002);
      t_auto(28'h0004081, 28'h0000083);
      report_and_stop;
   end
endmodule // scope_trigger_integration_cfg_test
bind scope_trigger_integration_cfg scope_integ_assertions #(.SEC_CYCLES(SEC_CYCLES))
   scope_integ_assertions_i (.*);
